// file: mmpl_dev.sv
// Purpose: mode selection, startup and magnetic period counting
// Assumes: hall_pos_i already on clock_i
// Notes: config fetch abstracts the EEPROM transfer
`timescale 1ns/1ns
`default_nettype none
`include "mmpl_regs.svh"
module mmpl_dev
   import mmpl_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_b_i,
   mmpl_link_if.dev link,
   input wire logic [2:0] hall_pos_i,
   input wire logic vdd_ok_i,
   input wire logic bat_ok_i,
   output mmpl_pkg::mmpl_mode_e mode_o,
   output logic [39:0] mt_word_o,
   output logic [2:0] sync_o,
   output logic [2:0] par_p_o,
   output logic [2:0] par_n_o,
   output logic low_power_o,
   output logic scan_diff_o,
   output logic [1:0] scan_pole_o
);
   import mmpl_pkg::*;
   typedef enum logic [3:0] {ST_OFF, ST_PAR_ACQ, ST_PAR_OUT, ST_IDLE_LP, ST_LOAD,
      ST_SSI, ST_CHAIN, ST_SLAVE, ST_FAIL} mmpl_state_e;
   // ***********************************
   // State
   // ***********************************
   mmpl_state_e st_q, st_d;
   logic [7:0] ifc_q, ifc_d, ofs_q, ofs_d, ppr_q, ppr_d, scan_q, scan_d, outc_q, outc_d;
   logic pre_q, pre_d, sel_q, sel_d, bad_q, bad_d, req_q, req_d;
   logic [2:0] idx_q, idx_d, pos_q, pos_d;
   logic [1:0] try_q, try_d;
   logic [7:0] per_q, per_d, wait_q, wait_d, rdat_q, rdat_d;
   logic [39:0] cnt_q, cnt_d, word_q, word_d;
   logic ack_q, ack_d, lp_q, lp_d, diff_q, diff_d;
   logic [2:0] sync_q, sync_d, pp_q, pp_d, pn_q, pn_d;
   logic [2:0] pos_n, sync_w, cidx;
   logic [39:0] pos_word;
   logic counting, per_mode, hit;
   always_comb
   begin
      st_d = st_q;
      ifc_d = ifc_q;
      ofs_d = ofs_q;
      ppr_d = ppr_q;
      scan_d = scan_q;
      outc_d = outc_q;
      sel_d = sel_q;
      bad_d = bad_q;
      idx_d = idx_q;
      try_d = try_q;
      per_d = per_q;
      cnt_d = cnt_q;
      wait_d = wait_q;
      rdat_d = rdat_q;
      pp_d = pp_q;
      pn_d = pn_q;
      lp_d = lp_q;
      req_d = 1'b0;
      ack_d = 1'b0;
      pre_d = link.preset;
      // Direction first, then phase shift in eighth-period steps
      pos_n = (ifc_q[`MMPL_BIT_CODEREV] ? 3'(3'h0 - hall_pos_i) : hall_pos_i)
         + ofs_q[7:`MMPL_PHASE_LSB];
      pos_d = pos_n;
      counting = (st_q == ST_SSI) || (st_q == ST_CHAIN) || (st_q == ST_SLAVE);
      per_mode = outc_q[`MMPL_BIT_PEROUT] && (ppr_q != 8'h00);
      pos_word = per_mode ? {cnt_q[31:0], per_q} : cnt_q;
      // Sector of the whole revolution, exact for any period count
      sync_w = 3'({per_q, pos_q} / ({1'b0, ppr_q} + 9'h001));
      cidx = 3'(link.reg_addr - `MMPL_REG_CNT0);
      // ***********************************
      // Period and revolution counting
      // ***********************************
      if (counting)
      begin
         if (pos_q == 3'h7 && pos_n == 3'h0)
         begin
            if (per_q >= ppr_q)
            begin
               per_d = 8'h00;
               cnt_d = cnt_q + 40'h1;
            end
            else
               per_d = per_q + 8'h01;
         end
         else if (pos_q == 3'h0 && pos_n == 3'h7)
         begin
            if (per_q == 8'h00)
            begin
               per_d = ppr_q;
               cnt_d = cnt_q - 40'h1;
            end
            else
               per_d = per_q - 8'h01;
         end
         if (per_mode)
            cnt_d[39:32] = 8'h00;
         if (!bat_ok_i)
            st_d = ST_OFF;
      end
      // ***********************************
      // Register access, slave absent in chain mode
      // ***********************************
      hit = (link.reg_rd || link.reg_wr) && (link.reg_dev == `MMPL_SLAVE_ID)
         && (st_q == ST_SSI || st_q == ST_SLAVE);
      if (hit)
      begin
         ack_d = 1'b1;
         rdat_d = 8'h00;
         case (link.reg_addr)
            `MMPL_REG_IFC: rdat_d = ifc_q;
            `MMPL_REG_PHASE: rdat_d = ofs_q;
            `MMPL_REG_PPR: rdat_d = ppr_q;
            `MMPL_REG_SCAN: rdat_d = scan_q;
            `MMPL_REG_OUTC: rdat_d = outc_q;
            `MMPL_REG_SYNC: rdat_d = {5'h00, sync_q};
            `MMPL_REG_STAT: rdat_d = {5'h00, bat_ok_i, vdd_ok_i, bad_q};
            default:
               // Position only in slave mode, SSI port owns it otherwise
               if (link.reg_addr >= `MMPL_REG_CNT0 && link.reg_addr <= `MMPL_REG_CNT4
                  && st_q == ST_SLAVE)
                  rdat_d = 8'(pos_word >> {cidx, 3'h0});
         endcase
         if (link.reg_wr)
         begin
            case (link.reg_addr)
               `MMPL_REG_IFC: ifc_d = link.reg_wdata;
               `MMPL_REG_PHASE: ofs_d = link.reg_wdata;
               `MMPL_REG_PPR: ppr_d = link.reg_wdata;
               `MMPL_REG_SCAN: scan_d = {5'h00, link.reg_wdata[2:0]};
               `MMPL_REG_OUTC: outc_d = link.reg_wdata;
               `MMPL_REG_CMD:
                  if (link.reg_wdata == `MMPL_CMD_RELOAD)
                  begin
                     st_d = ST_LOAD;
                     idx_d = 3'h0;
                     try_d = 2'h0;
                     bad_d = 1'b0;
                  end
               default: ;
            endcase
         end
      end
      // ***********************************
      // Mode sequencing
      // ***********************************
      case (st_q)
         ST_LOAD:
         begin
            req_d = !link.cfg_ack;
            if (link.cfg_ack)
            begin
               case (idx_q)
                  3'h0: ifc_d = link.cfg_data;
                  3'h1: ofs_d = link.cfg_data;
                  3'h2: ppr_d = link.cfg_data;
                  3'h4: scan_d = {5'h00, link.cfg_data[2:0]};
                  3'h5: outc_d = link.cfg_data;
                  default: ;
               endcase
               bad_d = bad_q || link.cfg_err;
               idx_d = idx_q + 3'h1;
               if (idx_q == `MMPL_CFG_LAST)
               begin
                  idx_d = 3'h0;
                  bad_d = 1'b0;
                  if (!(bad_q || link.cfg_err))
                     st_d = ifc_d[`MMPL_BIT_INTMODE] ? ST_CHAIN : ST_SSI;
                  else if (try_q == `MMPL_TRIES_LAST)
                     st_d = ST_FAIL;
                  else
                     try_d = try_q + 2'h1;
               end
            end
         end
         ST_PAR_ACQ:
         begin
            // Inverted word first so every pair toggles on release
            pp_d = ~pos_n;
            pn_d = pos_n;
            wait_d = wait_q + 8'h01;
            if (wait_q == 8'(`MMPL_PROC_CYC - 1))
               st_d = ST_PAR_OUT;
         end
         ST_PAR_OUT:
         begin
            pp_d = pos_q;
            pn_d = ~pos_q;
            st_d = ST_IDLE_LP;
         end
         ST_IDLE_LP: lp_d = 1'b1;
         default: ;
      endcase
      // ***********************************
      // Preset pulse
      // ***********************************
      if (link.preset)
      begin
         st_d = ST_OFF;
         ifc_d = `MMPL_CFG_RST;
         ofs_d = `MMPL_CFG_RST;
         ppr_d = `MMPL_CFG_RST;
         scan_d = `MMPL_CFG_RST;
         outc_d = `MMPL_CFG_RST;
         per_d = 8'h00;
         cnt_d = 40'h0;
         idx_d = 3'h0;
         try_d = 2'h0;
         bad_d = 1'b0;
         wait_d = 8'h00;
         pp_d = 3'h0;
         pn_d = 3'h0;
         lp_d = 1'b0;
         req_d = 1'b0;
         ack_d = 1'b0;
         if (!pre_q)
            sel_d = link.mode_pin;
      end
      else if (pre_q)
      begin
         // Pin high at both edges: parallel; followed the pulse: tied
         if (sel_q && link.mode_pin)
            st_d = ST_PAR_ACQ;
         else if (sel_q)
            st_d = ST_SLAVE;
         else if (vdd_ok_i)
            st_d = ST_LOAD;
         else
            st_d = ST_FAIL;
      end
      sync_d = counting ? sync_w : 3'h0;
      word_d = (counting && st_q != ST_SLAVE) ? pos_word : 40'h0;
      diff_d = (scan_q[1:0] == 2'h0)
         || (scan_q[`MMPL_BIT_AXIAL] && scan_q[1:0] == 2'h1);
   end
   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         st_q <= ST_OFF;
         ifc_q <= `MMPL_CFG_RST;
         ofs_q <= `MMPL_CFG_RST;
         ppr_q <= `MMPL_CFG_RST;
         scan_q <= `MMPL_CFG_RST;
         outc_q <= `MMPL_CFG_RST;
         pre_q <= 1'b0;
         sel_q <= 1'b0;
         bad_q <= 1'b0;
         req_q <= 1'b0;
         idx_q <= 3'h0;
         pos_q <= 3'h0;
         try_q <= 2'h0;
         per_q <= 8'h00;
         wait_q <= 8'h00;
         rdat_q <= 8'h00;
         cnt_q <= 40'h0;
         word_q <= 40'h0;
         ack_q <= 1'b0;
         lp_q <= 1'b0;
         diff_q <= 1'b1;
         sync_q <= 3'h0;
         pp_q <= 3'h0;
         pn_q <= 3'h0;
      end
      else
      begin
         st_q <= st_d;
         ifc_q <= ifc_d;
         ofs_q <= ofs_d;
         ppr_q <= ppr_d;
         scan_q <= scan_d;
         outc_q <= outc_d;
         pre_q <= pre_d;
         sel_q <= sel_d;
         bad_q <= bad_d;
         req_q <= req_d && (st_d == ST_LOAD);
         idx_q <= idx_d;
         pos_q <= pos_d;
         try_q <= try_d;
         per_q <= per_d;
         wait_q <= wait_d;
         rdat_q <= rdat_d;
         cnt_q <= cnt_d;
         word_q <= word_d;
         ack_q <= ack_d;
         lp_q <= lp_d;
         diff_q <= diff_d;
         sync_q <= sync_d;
         pp_q <= pp_d;
         pn_q <= pn_d;
      end
   end
   // ***********************************
   // Outputs
   // ***********************************
   mmpl_mode_e md_q;
   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         md_q <= MMPL_MD_OFF;
      else
         case (st_q)
            ST_SSI: md_q <= MMPL_MD_SSI;
            ST_CHAIN: md_q <= MMPL_MD_CHAIN;
            ST_SLAVE: md_q <= MMPL_MD_SLAVE;
            ST_FAIL: md_q <= MMPL_MD_FAIL;
            ST_PAR_ACQ, ST_PAR_OUT, ST_IDLE_LP: md_q <= MMPL_MD_PAR;
            default: md_q <= MMPL_MD_OFF;
         endcase
   end
   assign link.cfg_req = req_q;
   assign link.cfg_addr = idx_q;
   assign link.reg_ack = ack_q;
   assign link.reg_rdata = rdat_q;
   assign link.error_output_n = (md_q != MMPL_MD_FAIL);
   assign mode_o = md_q;
   assign mt_word_o = word_q;
   assign sync_o = sync_q;
   assign par_p_o = pp_q;
   assign par_n_o = pn_q;
   assign low_power_o = lp_q;
   assign scan_diff_o = diff_q;
   assign scan_pole_o = scan_q[1:0];
endmodule
`default_nettype wire

// file: mmpl_host.sv
// Purpose: controller end: preset, mode pin, config image, register access
// Assumes: Avalon-MM master on clock_i
// Notes: waitrequest drops one cycle after a request
`timescale 1ns/1ns
`default_nettype none
`include "mmpl_regs.svh"
module mmpl_host
   import mmpl_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_b_i,
   mmpl_link_if.host link,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o
);
   import mmpl_pkg::*;
   logic wreq_q, wreq_d, lvl_q, lvl_d, tie_q, tie_d, fail_q, fail_d;
   logic pre_q, pre_d, pin_q, pin_d, cack_q, cack_d, cerr_q, cerr_d;
   logic rd_q, rd_d, wr_q, wr_d, busy_q, busy_d, nak_q, nak_d;
   logic [3:0] pcnt_q, pcnt_d, tmo_q, tmo_d;
   logic [7:0] cdat_q, cdat_d, rdat_q, rdat_d;
   logic [23:0] cmd_q, cmd_d;
   logic [31:0] rdd_q, rdd_d;
   logic [7:0] rom_q [0:5];
   logic [7:0] rom_d [0:5];
   logic take;
   logic [2:0] ri;
   always_comb
   begin
      wreq_d = !((avs_read_i || avs_write_i) && wreq_q);
      take = !wreq_q && (avs_read_i || avs_write_i);
      lvl_d = lvl_q;
      tie_d = tie_q;
      fail_d = fail_q;
      pcnt_d = pcnt_q;
      cmd_d = cmd_q;
      rd_d = 1'b0;
      wr_d = 1'b0;
      busy_d = busy_q;
      nak_d = nak_q;
      tmo_d = tmo_q;
      rdat_d = rdat_q;
      rdd_d = rdd_q;
      rom_d = rom_q;
      ri = 3'(avs_address_i[5:2] - 4'h4);
      // ***********************************
      // Avalon slave
      // ***********************************
      // Read data registered at the request edge so it stands while waitrequest is low
      if (wreq_q && avs_read_i)
      begin
         case (avs_address_i)
            `MMPL_H_CTRL: rdd_d = {28'h0, fail_q, tie_q, lvl_q, pcnt_q != 4'h0};
            `MMPL_H_CMD: rdd_d = {8'h00, cmd_q};
            `MMPL_H_STAT: rdd_d = {17'h0, link.error_output_n, nak_q, busy_q,
               pcnt_q != 4'h0, 3'h0, rdat_q};
            default:
               rdd_d = (avs_address_i >= `MMPL_H_ROM && avs_address_i <= `MMPL_H_ROM_LAST)
                  ? {24'h0, rom_q[ri]} : 32'h0;
         endcase
      end
      if (take && avs_write_i && avs_byteenable_i[0])
      begin
         case (avs_address_i)
            `MMPL_H_CTRL:
            begin
               lvl_d = avs_writedata_i[1];
               tie_d = avs_writedata_i[2];
               fail_d = avs_writedata_i[3];
               if (avs_writedata_i[0] && pcnt_q == 4'h0)
                  pcnt_d = 4'(`MMPL_PRESET_CYC);
            end
            `MMPL_H_CMD:
               if (!busy_q)
               begin
                  cmd_d = avs_writedata_i[23:0];
                  wr_d = avs_writedata_i[16];
                  rd_d = !avs_writedata_i[16];
                  busy_d = 1'b1;
                  nak_d = 1'b0;
                  tmo_d = 4'h0;
               end
            default:
               if (avs_address_i >= `MMPL_H_ROM && avs_address_i <= `MMPL_H_ROM_LAST)
                  rom_d[ri] = avs_writedata_i[7:0];
         endcase
      end
      // ***********************************
      // Link side
      // ***********************************
      if (pcnt_q != 4'h0)
         pcnt_d = pcnt_q - 4'h1;
      pre_d = (pcnt_d != 4'h0);
      pin_d = tie_d ? pre_d : lvl_d;
      if (busy_q && !rd_q && !wr_q)
      begin
         tmo_d = tmo_q + 4'h1;
         if (link.reg_ack)
         begin
            busy_d = 1'b0;
            rdat_d = link.reg_rdata;
         end
         else if (tmo_q == `MMPL_H_TMO)
         begin
            busy_d = 1'b0;
            nak_d = 1'b1;
         end
      end
      // Image must obey axial scan implies pole code 1
      cack_d = link.cfg_req && !cack_q;
      cdat_d = (link.cfg_addr < 3'h6) ? rom_q[link.cfg_addr] : 8'h00;
      cerr_d = fail_q;
   end
   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         wreq_q <= 1'b1;
         lvl_q <= 1'b0;
         tie_q <= 1'b0;
         fail_q <= 1'b0;
         pre_q <= 1'b0;
         pin_q <= 1'b0;
         cack_q <= 1'b0;
         cerr_q <= 1'b0;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         busy_q <= 1'b0;
         nak_q <= 1'b0;
         pcnt_q <= 4'h0;
         tmo_q <= 4'h0;
         cdat_q <= 8'h00;
         rdat_q <= 8'h00;
         cmd_q <= 24'h0;
         rdd_q <= 32'h0;
         for (int i = 0; i < 6; i++)
            rom_q[i] <= 8'h00;
      end
      else
      begin
         wreq_q <= wreq_d;
         lvl_q <= lvl_d;
         tie_q <= tie_d;
         fail_q <= fail_d;
         pre_q <= pre_d;
         pin_q <= pin_d;
         cack_q <= cack_d;
         cerr_q <= cerr_d;
         rd_q <= rd_d;
         wr_q <= wr_d;
         busy_q <= busy_d;
         nak_q <= nak_d;
         pcnt_q <= pcnt_d;
         tmo_q <= tmo_d;
         cdat_q <= cdat_d;
         rdat_q <= rdat_d;
         cmd_q <= cmd_d;
         rdd_q <= rdd_d;
         rom_q <= rom_d;
      end
   end
   assign link.preset = pre_q;
   assign link.mode_pin = pin_q;
   assign link.cfg_ack = cack_q;
   assign link.cfg_err = cerr_q;
   assign link.cfg_data = cdat_q;
   assign link.reg_rd = rd_q;
   assign link.reg_wr = wr_q;
   assign link.reg_dev = cmd_q[23:17];
   assign link.reg_addr = cmd_q[4:0];
   assign link.reg_wdata = cmd_q[15:8];
   assign avs_readdata_o = rdd_q;
   assign avs_waitrequest_o = wreq_q;
endmodule
`default_nettype wire

// file: mmpl_link_chk.sv
// Purpose: link checker
// Assumes: one clock, async low reset
// Notes: instantiated beside the link
`timescale 1ns/1ns
`default_nettype none
module mmpl_link_chk (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic preset,
   input wire logic mode_pin,
   input wire logic cfg_req,
   input wire logic [2:0] cfg_addr,
   input wire logic cfg_ack,
   input wire logic cfg_err,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [6:0] reg_dev,
   input wire logic reg_ack,
   input wire logic error_output_n
);
   // ****
   // Properties
   // ****
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   sequence tied_fall;
      $fell(preset) && $fell(mode_pin);
   endsequence
   sequence par_fall;
      $fell(preset) && mode_pin;
   endsequence
   ack_cause_a: assert property (reg_ack |-> $past(reg_rd | reg_wr) && $past(reg_dev) == 7'h61)
      else $error("ack without addressed request");
   ack_pulse_a: assert property (reg_ack |=> !reg_ack)
      else $error("ack longer than one cycle");
   fetch_range_a: assert property (cfg_req |-> cfg_addr <= 3'h5)
      else $error("fetch address out of range");
   req_drop_a: assert property (cfg_ack |=> !cfg_req)
      else $error("fetch request held after ack");
   addr_step_a: assert property (cfg_ack && !cfg_err && cfg_addr != 3'h5 |=>
      cfg_addr == $past(cfg_addr) + 3'h1)
      else $error("fetch address not stepped");
   tied_quiet_a: assert property (tied_fall |=> !cfg_req [*8])
      else $error("fetch after tied preset");
   par_quiet_a: assert property (par_fall |=> !cfg_req [*8])
      else $error("fetch in parallel mode");
   preset_clear_a: assert property (preset [*3] |-> error_output_n && !cfg_req)
      else $error("state not cleared by preset");
   fail_stop_a: assert property (!error_output_n |-> !cfg_req)
      else $error("fetch retried after failure");
endmodule
`default_nettype wire

// file: mmpl_link_if.sv
// Purpose: pins between the counter device and its controller
// Assumes: both ends on clock_i
// Notes: register access uses single-cycle strobes; cfg_req is held until cfg_ack, which is a single-cycle strobe
`timescale 1ns/1ns
`default_nettype none
interface mmpl_link_if;
   logic preset;
   logic mode_pin;
   logic cfg_req;
   logic [2:0] cfg_addr;
   logic cfg_ack;
   logic cfg_err;
   logic [7:0] cfg_data;
   logic reg_rd;
   logic reg_wr;
   logic [6:0] reg_dev;
   logic [4:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_ack;
   logic [7:0] reg_rdata;
   logic error_output_n;
   modport dev (input preset, mode_pin, cfg_ack, cfg_err, cfg_data, reg_rd, reg_wr,
      reg_dev, reg_addr, reg_wdata, output cfg_req, cfg_addr, reg_ack, reg_rdata,
      error_output_n);
   modport host (output preset, mode_pin, cfg_ack, cfg_err, cfg_data, reg_rd, reg_wr,
      reg_dev, reg_addr, reg_wdata, input cfg_req, cfg_addr, reg_ack, reg_rdata,
      error_output_n);
endinterface
`default_nettype wire

// file: mmpl_pkg.sv
// Purpose: shared types
// Assumes: nothing
// Notes: constants live in mmpl_regs.svh
package mmpl_pkg;
   typedef enum logic [2:0] {MMPL_MD_OFF, MMPL_MD_SSI, MMPL_MD_CHAIN, MMPL_MD_PAR,
      MMPL_MD_SLAVE, MMPL_MD_FAIL} mmpl_mode_e;
endpackage

// file: mmpl_regs.svh
// Purpose: register offsets, field positions and timing counts
// Assumes: 10 MHz clock
// Notes: included by bare name
`ifndef MMPL_REGS_SVH
`define MMPL_REGS_SVH
// ***********************************
// Timing
// ***********************************
`define MMPL_CLK_NS 100
`define MMPL_PROC_NS 10000
`define MMPL_PROC_CYC ((`MMPL_PROC_NS + `MMPL_CLK_NS - 1) / `MMPL_CLK_NS)
`define MMPL_PRESET_NS 1000
`define MMPL_PRESET_CYC ((`MMPL_PRESET_NS + `MMPL_CLK_NS - 1) / `MMPL_CLK_NS)
`define MMPL_H_TMO 4'hf
// ***********************************
// Device register map
// ***********************************
`define MMPL_SLAVE_ID 7'h61
`define MMPL_CMD_RELOAD 8'h01
`define MMPL_REG_IFC 5'h00
`define MMPL_REG_PHASE 5'h01
`define MMPL_REG_PPR 5'h02
`define MMPL_REG_SCAN 5'h04
`define MMPL_REG_OUTC 5'h05
`define MMPL_REG_CNT0 5'h07
`define MMPL_REG_CNT4 5'h0b
`define MMPL_REG_SYNC 5'h0d
`define MMPL_REG_STAT 5'h10
`define MMPL_REG_CMD 5'h11
`define MMPL_BIT_INTMODE 0
`define MMPL_BIT_CODEREV 3
`define MMPL_PHASE_LSB 5
`define MMPL_BIT_AXIAL 2
`define MMPL_BIT_PEROUT 6
`define MMPL_CFG_RST 8'h00
`define MMPL_CFG_LAST 3'h5
`define MMPL_TRIES_LAST 2'h2
// ***********************************
// Host register map (byte addresses)
// ***********************************
`define MMPL_H_CTRL 6'h00
`define MMPL_H_CMD 6'h04
`define MMPL_H_STAT 6'h08
`define MMPL_H_ROM 6'h10
`define MMPL_H_ROM_LAST 6'h24
`endif

// file: multiturn_mode_and_period_logic_bench.sv
// Purpose: bench for both link ends
// Assumes: 10 MHz clock
// Notes: device configured from the host image
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) \
   begin \
      compares++; \
      if ((s) !== (e)) \
      begin \
         failures++; \
         $display("[FAIL] %s exp %0h got %0h", nm, e, s); \
      end \
   end
module multiturn_mode_and_period_logic_bench;
   import mmpl_pkg::*;
   // ****
   // Harness
   // ****
   logic clock_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [5:0] adr = '0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic vdd = 1'b1;
   logic bat = 1'b1;
   logic [31:0] wd = '0;
   logic [31:0] rdat;
   logic [31:0] q;
   logic wt;
   logic [2:0] hall = '0;
   mmpl_mode_e mode;
   logic [39:0] mt;
   logic [2:0] sy, pp, pn;
   logic lp, sd;
   logic [1:0] sp;
   logic [7:0] rom [6];
   int failures = 0;
   int compares = 0;
   mmpl_link_if link ();
   always #50 clock_i = ~clock_i;
   mmpl_dev u_mmpl_dev (.clock_i(clock_i), .rst_b_i(rst_b_i), .link(link), .hall_pos_i(hall),
      .vdd_ok_i(vdd), .bat_ok_i(bat), .mode_o(mode), .mt_word_o(mt), .sync_o(sy),
      .par_p_o(pp), .par_n_o(pn), .low_power_o(lp), .scan_diff_o(sd), .scan_pole_o(sp));
   mmpl_host u_mmpl_host (.clock_i(clock_i), .rst_b_i(rst_b_i), .link(link),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(4'hf),
      .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wt));
   mmpl_link_chk u_mmpl_link_chk (.clock_i(clock_i), .rst_b_i(rst_b_i), .preset(link.preset),
      .mode_pin(link.mode_pin), .cfg_req(link.cfg_req), .cfg_addr(link.cfg_addr),
      .cfg_ack(link.cfg_ack), .cfg_err(link.cfg_err), .reg_rd(link.reg_rd),
      .reg_wr(link.reg_wr), .reg_dev(link.reg_dev), .reg_ack(link.reg_ack),
      .error_output_n(link.error_output_n));
   // Called just after a rising edge; returns just after one
   task automatic av(input logic [5:0] a, input logic w, input logic [31:0] d);
      int n;
      adr <= a;
      rd <= !w;
      wr <= w;
      wd <= d;
      n = 0;
      do @(posedge clock_i); while (wt !== 1'b0 && ++n < 100);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clock_i);
   endtask
   task automatic dreg(input logic w, input logic [6:0] id, input logic [4:0] a,
      input logic [7:0] d);
      int n;
      av(6'h04, 1'b1, {8'h00, id, w, d, 3'h0, a});
      n = 0;
      do av(6'h08, 1'b0, '0); while (q[12] !== 1'b0 && ++n < 40);
   endtask
   // Fixed wait covers the preset pulse only
   task automatic pre(input logic [3:0] c);
      av(6'h00, 1'b1, {28'h0, c});
      repeat (12) @(posedge clock_i);
   endtask
   task automatic till(input mmpl_mode_e m);
      int n;
      n = 0;
      while (mode !== m && ++n < 500) @(posedge clock_i);
   endtask
   task automatic end_of_test;
      if (failures == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      #2000000;
      failures++;
      end_of_test;
   end
   // ****
   // Scenarios
   // ****
   initial
   begin
      int s;
      logic [2:0] ph;
      logic [7:0] r;
      s = $urandom(81305);
      repeat (2) @(posedge clock_i);
      rst_b_i <= 1'b1;
      @(posedge clock_i);
      av(6'h08, 1'b0, '0);
      `CHK("err pin", 1'b1, q[14])
      `CHK("mode", MMPL_MD_OFF, mode)
      for (int k = 0; k < 4; k++)
      begin
         ph = k[0] ? 3'($urandom_range(4)) : 3'($urandom);
         rom = '{{7'h0, k[0]}, {ph, 5'h0}, 8'h00, 8'($urandom), {5'h0, k == 1, k[1:0]}, 8'h00};
         for (int i = 0; i < 6; i++)
            av(6'h10 + 6'(4 * i), 1'b1, {24'h0, rom[i]});
         hall <= 3'h0 - ph;
         pre(4'h1);
         till(k[0] ? MMPL_MD_CHAIN : MMPL_MD_SSI);
         `CHK("mode", k[0] ? MMPL_MD_CHAIN : MMPL_MD_SSI, mode)
         `CHK("pole", k[1:0], sp)
         `CHK("diff", k < 2, sd)
         for (int j = 1; j < 9; j++)
         begin
            hall <= 3'h0 - ph + 3'(j);
            repeat (3) @(posedge clock_i);
            `CHK("sector", 3'(j), sy)
         end
         `CHK("count", 40'h1, mt)
         dreg(1'b0, 7'h61, 5'h07, 8'h00);
         `CHK("nak", k[0], q[13])
         if (!k[0])
            `CHK("count reg", 8'h00, q[7:0])
      end
      pre(4'h7);
      till(MMPL_MD_SLAVE);
      `CHK("mode", MMPL_MD_SLAVE, mode)
      dreg(1'b0, 7'h60, 5'h02, 8'h00);
      `CHK("wrong id", 1'b1, q[13])
      r = 8'($urandom);
      dreg(1'b1, 7'h61, 5'h02, r);
      dreg(1'b0, 7'h61, 5'h02, 8'h00);
      `CHK("ppr", r, q[7:0])
      av(6'h00, 1'b1, 32'h2);
      repeat (5) @(posedge clock_i);
      `CHK("held", MMPL_MD_SLAVE, mode)
      // Reverse, three periods per turn, period in low byte
      dreg(1'b1, 7'h61, 5'h00, 8'h08);
      dreg(1'b1, 7'h61, 5'h02, 8'h02);
      dreg(1'b1, 7'h61, 5'h05, 8'h40);
      for (int j = 0; j < 8; j++)
      begin
         hall <= hall + 3'h1;
         repeat (3) @(posedge clock_i);
      end
      dreg(1'b0, 7'h61, 5'h07, 8'h00);
      `CHK("period", 8'h02, q[7:0])
      dreg(1'b0, 7'h61, 5'h08, 8'h00);
      `CHK("count low", 8'hff, q[7:0])
      dreg(1'b1, 7'h61, 5'h11, 8'h01);
      till(MMPL_MD_CHAIN);
      `CHK("reload", MMPL_MD_CHAIN, mode)
      hall <= 3'($urandom);
      pre(4'h3);
      till(MMPL_MD_PAR);
      `CHK("first", {~hall, hall}, {pp, pn})
      for (int n = 0; n < 300 && lp !== 1'b1; n++)
         @(posedge clock_i);
      `CHK("toggled", {hall, ~hall}, {pp, pn})
      av(6'h00, 1'b1, 32'h0);
      `CHK("held", MMPL_MD_PAR, mode)
      pre(4'h9);
      till(MMPL_MD_FAIL);
      av(6'h08, 1'b0, '0);
      `CHK("err pin", 1'b0, q[14])
      vdd <= 1'b0;
      pre(4'h1);
      till(MMPL_MD_FAIL);
      `CHK("no supply", MMPL_MD_FAIL, mode)
      vdd <= 1'b1;
      pre(4'h1);
      till(MMPL_MD_CHAIN);
      av(6'h08, 1'b0, '0);
      `CHK("err clear", 1'b1, q[14])
      end_of_test;
   end
endmodule
`default_nettype wire
